// >>> tb_top.sv
// Self-checking testbench of the serial control block
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import ucc_pkg::*;
();
    logic clock, rst, psel, penable, pwrite, pinDirBit, txDataWrite, rxFlagClear, idleClear;
    logic pready, pslverr, rxPin, rxPinOe, txPin, txPinOe, txBufEmpty, txDone, rxFull;
    logic idleFlag, parityErr, txIrq, rxIrq, errSeen;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdVal;
    logic [8:0] txData, rxData;
    logic [10:0] frame;
    int n_errors, comparisons, cycles, waited;

    ucc_serial_ctrl ucc_serial_ctrl_inst (.clock, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .rxPin, .pinDirBit, .rxPinOe, .txPin, .txPinOe,
        .txData, .txDataWrite, .rxData, .rxFlagClear, .idleClear, .txBufEmpty, .txDone,
        .rxFull, .idleFlag, .parityErr, .txIrq, .rxIrq);
    ucc_remote_xcvr ucc_remote_xcvr_inst (.clock, .txLine(txPin), .rxLine(rxPin));

    initial begin
        clock = 1'h0;
        forever #12.5 clock = ~clock;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
        @(posedge clock);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= {24'h000000, wd};
        @(posedge clock);
        penable <= 1'h1;
        do @(posedge clock); while (pready !== 1'h1);
        rdVal = prdata;
        errSeen = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    // Strobe bits, high first: txDataWrite, rxFlagClear, idleClear
    task automatic pulse(input logic [2:0] sel);
        @(posedge clock);
        {txDataWrite, rxFlagClear, idleClear} <= sel;
        @(posedge clock);
        {txDataWrite, rxFlagClear, idleClear} <= 3'h0;
    endtask : pulse

    // Flag bits, high first: rxFull, parityErr, idleFlag; bounded so a lost flag cannot hang
    task automatic waitHigh(input logic [2:0] sel);
        for (int i = 0; i < 24 * BIT_CYCLES && ({rxFull, parityErr, idleFlag} & sel) !== sel;
             i++) begin
            @(posedge clock);
        end
        repeat (2) @(posedge clock);
    endtask : waitHigh

    task automatic testReset();
        apb(1'h0, IDX_CTRL_ONE, 8'h00);
        check(rdVal, {24'h000000, CTRL_ONE_RESET});
        apb(1'h0, IDX_CTRL_TWO, 8'h00);
        check(rdVal, {24'h000000, CTRL_TWO_RESET});
        apb(1'h0, IDX_STATUS, 8'h00);
        check(rdVal, 32'h00000003);
        apb(1'h1, 10'h3FF, 8'hFF);
        check(32'(errSeen), 32'h1);
    endtask : testReset

    task automatic testPin();
        pinDirBit <= 1'h1;
        repeat (3) @(posedge clock);
        check(32'(rxPinOe), 32'h1);
        apb(1'h1, IDX_CTRL_ONE, 8'h40);
        repeat (3) @(posedge clock);
        check(32'(rxPinOe), 32'h0);
        check(32'(txPinOe), 32'h1);
    endtask : testPin

    task automatic testTx();
        logic [6:0] d;
        for (int odd = 0; odd < 2; odd++) begin
            d = (odd == 1) ? 7'h2A : 7'h35;
            // Parity select only changes while the line is quiet
            apb(1'h1, IDX_CTRL_ONE, 8'h42 | 8'(odd));
            apb(1'h1, IDX_CTRL_TWO, 8'h08);
            txData <= {2'h0, d};
            pulse(3'h4);
            ucc_remote_xcvr_inst.getFrame(10, frame, waited);
            check(32'(frame[9:0]), 32'({1'h1, ^d ^ 1'(odd), d, 1'h0}));
            check(32'(waited > 10 * BIT_CYCLES - 12 && waited < 11 * BIT_CYCLES + 12), 32'h1);
            apb(1'h1, IDX_CTRL_TWO, 8'h00);
        end
        apb(1'h1, IDX_CTRL_ONE, 8'h60);
        repeat (4) @(posedge clock);
        check(32'(txPin), 32'h0);
        apb(1'h1, IDX_CTRL_ONE, 8'h40);
    endtask : testTx

    task automatic testRx();
        apb(1'h1, IDX_CTRL_ONE, 8'h42);
        apb(1'h1, IDX_CTRL_TWO, 8'h24);
        ucc_remote_xcvr_inst.putFrame({2'h3, 8'hA5, 1'h0}, 10);
        waitHigh(3'h4);
        check(32'(rxData), 32'h0A5);
        check(32'({rxFull, parityErr, rxIrq}), 32'h5);
        apb(1'h1, IDX_CTRL_TWO, 8'h20);
        check(32'(rxFull), 32'h1);
        pulse(3'h2);
        repeat (2) @(posedge clock);
        check(32'({rxFull, rxIrq}), 32'h0);
        apb(1'h1, IDX_CTRL_TWO, 8'h24);
        ucc_remote_xcvr_inst.putFrame({2'h3, 8'h01, 1'h0}, 10);
        waitHigh(3'h2);
        check(32'(parityErr), 32'h1);
        waitHigh(3'h1);
        check(32'(idleFlag), 32'h1);
        pulse(3'h1);
        pulse(3'h2);
        repeat (2) @(posedge clock);
        check(32'({idleFlag, parityErr, rxFull}), 32'h0);
        apb(1'h1, IDX_CTRL_ONE, 8'h48);
        apb(1'h1, IDX_CTRL_TWO, 8'h26);
        ucc_remote_xcvr_inst.putFrame({2'h3, 8'h25, 1'h0}, 10);
        repeat (4) @(posedge clock);
        check(32'({rxFull, rxIrq}), 32'h0);
        ucc_remote_xcvr_inst.putFrame({2'h3, 8'hA5, 1'h0}, 10);
        waitHigh(3'h4);
        check(32'({rxFull, rxIrq}), 32'h3);
        apb(1'h0, IDX_CTRL_TWO, 8'h00);
        check(rdVal, 32'h00000024);
        // Idle-line wakeup: standby set on a line that is already idle
        apb(1'h1, IDX_CTRL_ONE, 8'h40);
        repeat (12 * BIT_CYCLES) @(posedge clock);
        pulse(3'h3);
        apb(1'h1, IDX_CTRL_TWO, 8'h26);
        repeat (4) @(posedge clock);
        apb(1'h0, IDX_CTRL_TWO, 8'h00);
        check(rdVal, 32'h00000024);
        check(32'({idleFlag, rxFull}), 32'h0);
    endtask : testRx

    task automatic testLoop();
        apb(1'h1, IDX_CTRL_ONE, 8'hD0);
        apb(1'h1, IDX_CTRL_TWO, 8'h0C);
        txData <= 9'h15A;
        pulse(3'h4);
        waitHigh(3'h4);
        check(32'({rxFull, rxData}), 32'h35A);
        apb(1'h1, IDX_CTRL_TWO, 8'h00);
        pulse(3'h2);
    endtask : testLoop

    task automatic testBreak();
        apb(1'h1, IDX_CTRL_ONE, 8'h40);
        apb(1'h1, IDX_CTRL_TWO, 8'h09);
        apb(1'h1, IDX_CTRL_TWO, 8'h08);
        ucc_remote_xcvr_inst.getFrame(11, frame, waited);
        check(32'(frame), 32'h400);
        check(32'(waited < BIT_CYCLES + 12), 32'h1);
        apb(1'h1, IDX_CTRL_TWO, 8'h00);
    endtask : testBreak

    task automatic testOff();
        apb(1'h1, IDX_CTRL_ONE, 8'h40);
        apb(1'h1, IDX_CTRL_TWO, 8'h88);
        repeat (3) @(posedge clock);
        check(32'(txIrq), 32'h1);
        txData <= 9'h055;
        pulse(3'h4);
        apb(1'h1, IDX_CTRL_ONE, 8'h00);
        repeat (3) @(posedge clock);
        check(32'({txBufEmpty, txDone, txIrq}), 32'h6);
    endtask : testOff

    task automatic summarize();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    // Whole run needs well under this many clocks
    always @(posedge clock) begin
        cycles++;
        if (cycles == 100000) begin
            n_errors++;
            summarize();
        end
    end

    initial begin
        {psel, penable, pwrite, pinDirBit, txDataWrite, rxFlagClear, idleClear} = '0;
        paddr = '0;
        pwdata = '0;
        txData = '0;
        rst = 1'h1;
        repeat (5) @(posedge clock);
        rst <= 1'h0;
        testReset();
        testPin();
        testTx();
        testRx();
        testLoop();
        testBreak();
        testOff();
        summarize();
    end
endmodule : tb_top
`default_nettype wire

// >>> ucc_pkg.sv
// Constants, register map and state types of the serial control block
package ucc_pkg;
    // Timing
    localparam int CLOCK_HZ = 40_000_000;
    localparam int BAUD_HZ = 115_200;
    localparam int BIT_CYCLES = CLOCK_HZ / BAUD_HZ;
    localparam logic [15:0] BIT_COUNT = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] HALF_COUNT = 16'(BIT_CYCLES / 2 - 1);
    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_CTRL_ONE = 10'h013;
    localparam logic [9:0] IDX_CTRL_TWO = 10'h014;
    localparam logic [9:0] IDX_STATUS = 10'h015;
    localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
    localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
    // serial_ctrl_one fields
    localparam int B_LOOP = 7;
    localparam int B_ON = 6;
    localparam int B_FLIP = 5;
    localparam int B_LEN = 4;
    localparam int B_WAKE = 3;
    localparam int B_IDLE_COUNT_FROM_STOP = 2;
    localparam int B_PAR_ON = 1;
    localparam int B_PAR_ODD = 0;
    // serial_ctrl_two fields
    localparam int B_TXE_IE = 7;
    localparam int B_TXD_IE = 6;
    localparam int B_RXF_IE = 5;
    localparam int B_IDLE_IE = 4;
    localparam int B_TX_EN = 3;
    localparam int B_RX_EN = 2;
    localparam int B_STBY = 1;
    localparam int B_BRK = 0;
    // Status fields
    localparam int S_TX_EMPTY = 0;
    localparam int S_TX_DONE = 1;
    localparam int S_RX_FULL = 2;
    localparam int S_IDLE = 3;
    localparam int S_PAR_ERR = 4;
    // Frame lengths in bits
    localparam logic [3:0] FRAME_SHORT = 4'hA;
    localparam logic [3:0] FRAME_LONG = 4'hB;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_PREAMBLE = 3'b001,
        TX_BREAK = 3'b010,
        TX_DATA = 3'b011,
        TX_MARK = 3'b100
    } ucc_tx_state_t;

    typedef enum logic [0:0] {
        RX_IDLE = 1'b0,
        RX_BITS = 1'b1
    } ucc_rx_state_t;
endpackage : ucc_pkg

// >>> ucc_remote_xcvr.sv
// Remote serial transceiver facing the block's pins
`timescale 1ns/1ps
`default_nettype none
module ucc_remote_xcvr
    import ucc_pkg::*;
(
    input wire logic clock, // Module clock
    input wire logic txLine, // Block's transmit pin
    output logic rxLine // Drives the block's receive pin
);
    // Line rests high between frames, as a pulled-up wire would
    initial rxLine = 1'h1;
    task automatic putFrame(input logic [10:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            rxLine <= bits[i];
            repeat (BIT_CYCLES) @(posedge clock);
        end
        rxLine <= 1'h1;
    endtask : putFrame
    // Samples mid-bit; waited counts clocks until the start bit
    task automatic getFrame(input int n, output logic [10:0] bits, output int waited);
        waited = 0;
        bits = '0;
        while (txLine !== 1'h0) begin
            @(posedge clock);
            waited++;
        end
        repeat (BIT_CYCLES / 2) @(posedge clock);
        for (int i = 0; i < n; i++) begin
            bits[i] = txLine;
            repeat (BIT_CYCLES) @(posedge clock);
        end
    endtask : getFrame
endmodule : ucc_remote_xcvr
`default_nettype wire

// >>> ucc_serial_ctrl.sv
// Serial port control registers, transmitter framing, receiver wakeup and requests
`timescale 1ns/1ps
`default_nettype none
module ucc_serial_ctrl
    import ucc_pkg::*;
(
    input wire logic clock, // Module clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic rxPin, // Receive pin, asynchronous
    input wire logic pinDirBit, // Port direction bit of the shared pin
    output logic rxPinOe, // Port drives the shared receive pin
    output logic txPin, // Transmit pin level
    output logic txPinOe, // Transmit pin driven by the port
    input wire logic [8:0] txData, // Character for the transmit buffer
    input wire logic txDataWrite, // Load pulse for txData
    output logic [8:0] rxData, // Last delivered character
    input wire logic rxFlagClear, // Clears receive-full and parity error
    input wire logic idleClear, // Clears idle flag
    output logic txBufEmpty, // Transmit buffer empty flag
    output logic txDone, // Transmission complete flag
    output logic rxFull, // Receive full flag
    output logic idleFlag, // Idle line flag
    output logic parityErr, // Parity error flag
    output logic txIrq, // Transmitter request
    output logic rxIrq // Receiver request
);
    typedef struct packed {
        logic [7:0] ctrlOne;
        logic [7:0] ctrlTwo;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        ucc_tx_state_t txState;
        logic [15:0] txBaud;
        logic [3:0] txCnt;
        logic [10:0] txShift;
        logic [8:0] txBuf;
        logic txBufEmpty;
        logic txDone;
        logic preamblePend;
        logic breakPend;
        logic txRaw;
        logic txLine;
        logic rxSync1;
        logic rxSync2;
        logic rxPrev;
        ucc_rx_state_t rxState;
        logic [15:0] rxBaud;
        logic [3:0] rxCnt;
        logic [10:0] rxShift;
        logic [3:0] idleRun;
        logic idleArmed;
        logic rxFull;
        logic idleFlag;
        logic parityErr;
        logic [8:0] rxData;
        logic txIrq;
        logic rxIrq;
        logic rxPinOe;
        logic txPinOe;
    } ucc_state_t;

    ucc_state_t st;
    ucc_state_t next_st;

    function automatic logic parityBit(input logic [8:0] d, input logic len, input logic odd);
        parityBit = (len ? ^d[7:0] : ^d[6:0]) ^ odd;
    endfunction : parityBit

    function automatic logic [10:0] makeFrame(input logic [8:0] d, input logic [7:0] c1);
        logic [8:0] body;
        body = d;
        if (c1[B_PAR_ON]) begin
            if (c1[B_LEN]) begin
                body[8] = parityBit(d, 1'b1, c1[B_PAR_ODD]);
            end else begin
                body[7] = parityBit(d, 1'b0, c1[B_PAR_ODD]);
            end
        end
        if (c1[B_LEN]) begin
            makeFrame = {1'b1, body, 1'b0};
        end else begin
            makeFrame = {1'b1, 1'b1, body[7:0], 1'b0};
        end
    endfunction : makeFrame

    logic on;
    logic [3:0] frameLen;
    logic txTick;
    logic rxTick;
    logic rxSrc;
    logic pick;
    logic access;
    logic [8:0] rxChar;
    logic rxMsb;
    logic rxErr;

    always_comb begin
        next_st = st;
        rxChar = 9'h000;
        rxMsb = 1'b0;
        rxErr = 1'b0;
        on = st.ctrlOne[B_ON];
        frameLen = st.ctrlOne[B_LEN] ? FRAME_LONG : FRAME_SHORT;
        access = psel & penable & st.pready;

        // Bus slave: no wait states, answer prepared in the setup cycle
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;
        if (psel && !penable) begin
            next_st.pready = 1'b1;
            next_st.prdata = 32'h0000_0000;
            case (paddr[11:2])
                IDX_CTRL_ONE: next_st.prdata[7:0] = st.ctrlOne;
                IDX_CTRL_TWO: next_st.prdata[7:0] = st.ctrlTwo;
                IDX_STATUS: next_st.prdata[4:0] = {st.parityErr, st.idleFlag, st.rxFull,
                                                   st.txDone, st.txBufEmpty};
                default: next_st.pslverr = 1'b1;
            endcase
        end
        if (access && pwrite) begin
            if (paddr[11:2] == IDX_CTRL_ONE) begin
                next_st.ctrlOne = pwdata[7:0];
            end else if (paddr[11:2] == IDX_CTRL_TWO) begin
                next_st.ctrlTwo = pwdata[7:0];
                // A fresh enable queues a preamble, also mid-frame
                if (pwdata[B_TX_EN] && !st.ctrlTwo[B_TX_EN]) begin
                    next_st.preamblePend = 1'b1;
                end
                if (pwdata[B_BRK] && !st.ctrlTwo[B_BRK]) begin
                    next_st.breakPend = 1'b1;
                end
            end
        end

        // Transmitter
        txTick = on && (st.txBaud == 16'h0000);
        next_st.txBaud = (!on || txTick) ? BIT_COUNT : st.txBaud - 16'h0001;
        pick = txTick && (st.txState == TX_IDLE || st.txCnt == 4'h1);
        if (txTick && !pick) begin
            next_st.txCnt = st.txCnt - 4'h1;
            if (st.txState == TX_DATA) begin
                next_st.txRaw = st.txShift[0];
                next_st.txShift = {1'b1, st.txShift[10:1]};
            end
        end
        if (pick) begin
            // Only at a character boundary, so disabling finishes the frame
            next_st.txState = TX_IDLE;
            next_st.txRaw = 1'b1;
            if (st.txState == TX_BREAK && !st.ctrlTwo[B_BRK] && !st.breakPend) begin
                next_st.txState = TX_MARK;
                next_st.txCnt = 4'h1;
            end else if (st.ctrlTwo[B_TX_EN]) begin
                if (st.breakPend || st.ctrlTwo[B_BRK]) begin
                    // Break wins over a preamble not yet begun
                    next_st.txState = TX_BREAK;
                    next_st.breakPend = 1'b0;
                    next_st.preamblePend = 1'b0;
                    next_st.txCnt = frameLen;
                    next_st.txRaw = 1'b0;
                end else if (st.preamblePend) begin
                    next_st.txState = TX_PREAMBLE;
                    next_st.preamblePend = 1'b0;
                    next_st.txCnt = frameLen;
                end else if (!st.txBufEmpty) begin
                    next_st.txState = TX_DATA;
                    next_st.txShift = makeFrame(st.txBuf, st.ctrlOne);
                    next_st.txRaw = 1'b0;
                    next_st.txShift = {1'b1, next_st.txShift[10:1]};
                    next_st.txCnt = frameLen;
                    next_st.txBufEmpty = 1'b1;
                end
            end
        end
        if (txDataWrite && on) begin
            next_st.txBuf = txData;
            next_st.txBufEmpty = 1'b0;
        end
        if (!on) begin
            next_st.txState = TX_IDLE;
            next_st.txRaw = 1'b1;
            next_st.txBufEmpty = 1'b1;
            next_st.preamblePend = 1'b0;
            next_st.breakPend = 1'b0;
        end
        next_st.txDone = next_st.txBufEmpty && next_st.txState == TX_IDLE
                         && !next_st.preamblePend && !next_st.breakPend;
        next_st.txLine = next_st.txRaw ^ next_st.ctrlOne[B_FLIP];

        // Receiver; the first sync stage feeds only the second
        next_st.rxSync1 = rxPin;
        next_st.rxSync2 = st.rxSync1;
        rxSrc = st.ctrlOne[B_LOOP] ? st.txLine : st.rxSync2;
        next_st.rxPrev = rxSrc;
        rxTick = (st.rxBaud == 16'h0000);
        next_st.rxBaud = rxTick ? BIT_COUNT : st.rxBaud - 16'h0001;
        if (rxFlagClear) begin
            next_st.rxFull = 1'b0;
            next_st.parityErr = 1'b0;
        end
        if (idleClear) begin
            next_st.idleFlag = 1'b0;
        end
        if (!on || !st.ctrlTwo[B_RX_EN]) begin
            // Flags keep their values while the receiver is off
            next_st.rxState = RX_IDLE;
            next_st.idleRun = 4'h0;
        end else if (st.rxState == RX_IDLE) begin
            if (st.rxPrev && !rxSrc) begin
                next_st.rxState = RX_BITS;
                next_st.rxBaud = HALF_COUNT;
                next_st.rxCnt = 4'h0;
                next_st.idleRun = 4'h0;
            end else if (rxTick && rxSrc && st.idleRun != 4'hF) begin
                next_st.idleRun = st.idleRun + 4'h1;
            end
        end else if (rxTick) begin
            if (st.rxCnt == 4'h0) begin
                if (rxSrc) begin
                    next_st.rxState = RX_IDLE;
                end else begin
                    next_st.rxCnt = 4'h1;
                    if (!st.ctrlOne[B_IDLE_COUNT_FROM_STOP]) begin
                        next_st.idleRun = 4'h0;
                    end
                end
            end else begin
                next_st.rxShift = {rxSrc, st.rxShift[10:1]};
                next_st.rxCnt = st.rxCnt + 4'h1;
                if (!st.ctrlOne[B_IDLE_COUNT_FROM_STOP]) begin
                    next_st.idleRun = rxSrc ? st.idleRun + 4'h1 : 4'h0;
                end
                if (st.rxCnt == frameLen - 4'h1) begin
                    next_st.rxState = RX_IDLE;
                    if (st.ctrlOne[B_IDLE_COUNT_FROM_STOP]) begin
                        next_st.idleRun = 4'h0;
                    end
                    rxChar = st.ctrlOne[B_LEN] ? next_st.rxShift[9:1]
                                               : {1'b0, next_st.rxShift[9:2]};
                    rxMsb = st.ctrlOne[B_LEN] ? rxChar[8] : rxChar[7];
                    rxErr = st.ctrlOne[B_PAR_ON] &&
                            (rxMsb != parityBit(rxChar, st.ctrlOne[B_LEN],
                                                st.ctrlOne[B_PAR_ODD]));
                    if (st.ctrlTwo[B_STBY] && st.ctrlOne[B_WAKE] && rxMsb) begin
                        next_st.ctrlTwo[B_STBY] = 1'b0;
                    end
                    if (!st.ctrlTwo[B_STBY] || (st.ctrlOne[B_WAKE] && rxMsb)) begin
                        next_st.rxData = rxChar;
                        next_st.rxFull = 1'b1;
                        next_st.parityErr = st.parityErr | rxErr | next_st.parityErr;
                        next_st.idleArmed = 1'b1;
                    end
                end
            end
        end
        if (on && st.ctrlTwo[B_RX_EN] && st.idleRun >= frameLen) begin
            if (st.ctrlTwo[B_STBY]) begin
                if (!st.ctrlOne[B_WAKE]) begin
                    // Level test, so standby set on an idle line wakes
                    next_st.ctrlTwo[B_STBY] = 1'b0;
                    next_st.idleArmed = 1'b0;
                end
            end else if (st.idleArmed) begin
                next_st.idleFlag = 1'b1;
                next_st.idleArmed = 1'b0;
            end
        end

        // Requests and pin steering
        next_st.txIrq = next_st.ctrlOne[B_ON] &&
                        ((next_st.ctrlTwo[B_TXE_IE] && next_st.txBufEmpty) ||
                         (next_st.ctrlTwo[B_TXD_IE] && next_st.txDone));
        next_st.rxIrq = !next_st.ctrlTwo[B_STBY] &&
                        ((next_st.ctrlTwo[B_RXF_IE] && next_st.rxFull) ||
                         (next_st.ctrlTwo[B_IDLE_IE] && next_st.idleFlag));
        next_st.rxPinOe = !next_st.ctrlOne[B_ON] && pinDirBit;
        next_st.txPinOe = next_st.ctrlOne[B_ON];
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st <= '0;
            st.ctrlOne <= CTRL_ONE_RESET;
            st.ctrlTwo <= CTRL_TWO_RESET;
            st.txState <= TX_IDLE;
            st.rxState <= RX_IDLE;
            st.txBufEmpty <= 1'b1;
            st.txDone <= 1'b1;
            st.txRaw <= 1'b1;
            st.txLine <= 1'b1;
            st.txShift <= 11'h7FF;
            st.txBaud <= BIT_COUNT;
            st.rxBaud <= BIT_COUNT;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign rxPinOe = st.rxPinOe;
    assign txPin = st.txLine;
    assign txPinOe = st.txPinOe;
    assign rxData = st.rxData;
    assign txBufEmpty = st.txBufEmpty;
    assign txDone = st.txDone;
    assign rxFull = st.rxFull;
    assign idleFlag = st.idleFlag;
    assign parityErr = st.parityErr;
    assign txIrq = st.txIrq;
    assign rxIrq = st.rxIrq;
endmodule : ucc_serial_ctrl
`default_nettype wire

// >>> ucc_serial_ctrl_properties.sv
// Port checker of the serial control block
`timescale 1ns/1ps
`default_nettype none
module ucc_serial_ctrl_properties
    import ucc_pkg::*;
(
    input wire logic clock, // Module clock
    input wire logic rst, // Synchronous reset
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pready, // APB ready
    input wire logic txDataWrite, // Buffer load
    input wire logic rxFlagClear, // Receive flag clear
    input wire logic idleClear, // Idle flag clear
    input wire logic rxPinOe, // Receive pin drive
    input wire logic txPinOe, // Port enabled
    input wire logic txBufEmpty, // Empty flag
    input wire logic txDone, // Done flag
    input wire logic rxFull, // Full flag
    input wire logic idleFlag, // Idle flag
    input wire logic parityErr, // Parity flag
    input wire logic txIrq, // Tx request
    input wire logic rxIrq // Rx request
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence sSetup; psel && !penable; endsequence
    sequence sAccess; psel && penable; endsequence
    AST_APB_ANSWER: assert property (sSetup ##1 sAccess |-> pready)
        else $error("access cycle without ready");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    AST_RX_PIN_IN: assert property (txPinOe && $past(txPinOe) |-> !rxPinOe)
        else $error("receive pin driven while port on");
    AST_OFF_FLAGS: assert property ($fell(txPinOe) |-> ##[0:2] (txBufEmpty && txDone))
        else $error("flags not set when port off");
    AST_OFF_NO_TXIRQ: assert property (!txPinOe && !$past(txPinOe) && !$past(txPinOe, 2) |-> !txIrq)
        else $error("tx request while port off");
    AST_TXIRQ_CAUSE: assert property (txIrq |-> txBufEmpty || txDone || $past(txBufEmpty || txDone))
        else $error("tx request without flag");
    AST_RXIRQ_CAUSE: assert property (rxIrq |-> rxFull || idleFlag || $past(rxFull || idleFlag))
        else $error("rx request without flag");
    AST_FULL_HOLD: assert property ($fell(rxFull) |-> $past(rxFlagClear) || $past(rxFlagClear, 2))
        else $error("full flag lost without clear");
    AST_IDLE_HOLD: assert property ($fell(idleFlag) |-> $past(idleClear) || $past(idleClear, 2))
        else $error("idle flag lost without clear");
    AST_PAR_HOLD: assert property ($fell(parityErr) |-> $past(rxFlagClear) || $past(rxFlagClear, 2))
        else $error("parity flag lost without clear");
    AST_EMPTY_LOAD: assert property ($fell(txBufEmpty) |-> $past(txDataWrite) || $past(txDataWrite, 2))
        else $error("empty flag fell without load");
endmodule : ucc_serial_ctrl_properties
bind ucc_serial_ctrl ucc_serial_ctrl_properties ucc_serial_ctrl_properties_inst (
    .clock, .rst, .psel, .penable, .pready, .txDataWrite, .rxFlagClear, .idleClear,
    .rxPinOe, .txPinOe, .txBufEmpty, .txDone, .rxFull, .idleFlag, .parityErr, .txIrq, .rxIrq
);
`default_nettype wire
